// >>> verilog/fcs_pkg.sv
// Purpose: shared constants and carriers for the fast counter status block
// Assumes: 32-bit APB, one word per register
// Notes:   offsets are byte addresses
package fcs_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_FLAGS     = 12'h000;
  localparam logic [11:0] OFS_POSITION  = 12'h004;
  localparam logic [11:0] OFS_FAULT     = 12'h008;
  localparam logic [11:0] OFS_ACCUM     = 12'h00C;
  localparam logic [11:0] OFS_UPPER_TGT = 12'h010;
  localparam logic [11:0] OFS_LOWER_TGT = 12'h014;
  localparam logic [11:0] OFS_UPPER_PAT = 12'h018;
  localparam logic [11:0] OFS_LOWER_PAT = 12'h01C;
  localparam logic [11:0] OFS_OVER_LIM  = 12'h020;
  localparam logic [11:0] OFS_UNDER_LIM = 12'h024;

  // bit positions in the flags register
  localparam int BIT_ENABLED     = 0;
  localparam int BIT_FAULT       = 1;
  localparam int BIT_UP_ACT      = 2;
  localparam int BIT_DOWN_ACT    = 3;
  localparam int BIT_SHOT_DONE   = 4;
  localparam int BIT_OVER        = 5;
  localparam int BIT_UNDER       = 6;
  localparam int BIT_DIRECTION   = 7;
  localparam int BIT_UPPER_HIT   = 8;
  localparam int BIT_LOWER_HIT   = 9;
  localparam int BIT_CAUSE_OVER  = 10;
  localparam int BIT_CAUSE_UNDER = 11;
  localparam int BIT_CAUSE_UPPER = 12;
  localparam int BIT_CAUSE_LOWER = 13;

  // commands and modes
  localparam logic [7:0] CMD_COUNT      = 8'h01;
  localparam logic [3:0] MODE_FIRST_BI  = 4'h2;
  localparam logic [3:0] MODE_LAST      = 4'h9;

  // reset values
  localparam logic [15:0] POSITION_START = 16'h0000;
  localparam logic [31:0] OVER_LIM_RST   = 32'h7FFFFFFF;
  localparam logic [31:0] UNDER_LIM_RST  = 32'h80000000;
  localparam logic [31:0] WORD_ZERO      = 32'h00000000;

  // preset bundle loaded by the counting core
  typedef struct packed {
    logic [31:0] upper_target;
    logic [31:0] lower_target;
    logic [31:0] upper_pattern;
    logic [31:0] lower_pattern;
  } fcs_preset_t;

  // interrupt triggers from the counting core
  typedef struct packed {
    logic over;
    logic under;
    logic upper;
    logic lower;
  } fcs_irq_t;

endpackage

// >>> verilog/fcs_status_block.sv
// Purpose: status record of a fast pulse counter, reachable over APB
// Assumes: core inputs are synchronous to clk; ce low freezes all state
// Notes:   zero-wait APB slave, read data registered in the setup phase
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none

module fcs_status_block #(
  parameter int ADDR_W = 12
) (
  // clock, reset, enable
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 ce,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic [31:0]               prdata,
  // counting core
  input  wire logic [7:0]           count_cmd,
  input  wire logic                 count_enable,
  input  wire logic [3:0]           count_mode,
  input  wire logic                 step_up,
  input  wire logic                 step_down,
  input  wire logic                 preset_load,
  input  wire fcs_pkg::fcs_preset_t preset_in,
  input  wire fcs_pkg::fcs_irq_t    irq_trigger,
  input  wire logic                 fault_valid,
  input  wire logic [15:0]          fault_code_in,
  input  wire logic                 table_step,
  input  wire logic                 table_at_end,
  // to the counting core
  output logic [31:0]               count_value,
  output logic [31:0]               upper_pattern_out,
  output logic [31:0]               lower_pattern_out
);

  logic               counting_enabled_bit;
  logic               fault_present_bit;
  logic               up_activity_bit;
  logic               down_activity_bit;
  logic               single_shot_done_bit;
  logic               over_limit_bit;
  logic               under_limit_bit;
  logic               direction_bit;
  logic               upper_target_hit_bit;
  logic               lower_target_hit_bit;
  logic               over_limit_irq_cause;
  logic               under_limit_irq_cause;
  logic               upper_target_irq_cause;
  logic               lower_target_irq_cause;
  logic [15:0]        limit_table_position;
  logic [15:0]        fault_code;
  logic signed [31:0] accumulator;
  logic signed [31:0] last_upper_target;
  logic signed [31:0] last_lower_target;
  logic [31:0]        last_upper_output_pattern;
  logic [31:0]        last_lower_output_pattern;
  logic signed [31:0] over_setting;
  logic signed [31:0] under_setting;

  logic               running;
  logic               bidir_mode;
  logic               single_mode;
  logic               up_evt;
  logic               down_evt;
  logic               upper_reach;
  logic               new_cause;
  logic signed [31:0] acc_inc;
  logic               wr_en;
  logic               setup;
  logic [31:0]        clr;
  logic [31:0]        flags_word;
  logic [31:0]        next_prdata;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic [11:0] o;
    o = 12'(a);
    addr_mapped = (o == fcs_pkg::OFS_FLAGS) || (o == fcs_pkg::OFS_POSITION) ||
                  (o == fcs_pkg::OFS_FAULT) || (o == fcs_pkg::OFS_ACCUM) ||
                  (o == fcs_pkg::OFS_UPPER_TGT) || (o == fcs_pkg::OFS_LOWER_TGT) ||
                  (o == fcs_pkg::OFS_UPPER_PAT) || (o == fcs_pkg::OFS_LOWER_PAT) ||
                  (o == fcs_pkg::OFS_OVER_LIM) || (o == fcs_pkg::OFS_UNDER_LIM);
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    hit = (12'(a) == ofs);
  endfunction

  // bus decode, zero wait states while enabled
  assign pready  = ce;
  assign pslverr = psel & penable & ~addr_mapped(paddr);
  assign setup   = ce & psel & ~penable;
  assign wr_en   = ce & psel & penable & pwrite & addr_mapped(paddr);
  assign clr     = (wr_en && hit(paddr, fcs_pkg::OFS_FLAGS)) ? pwdata : fcs_pkg::WORD_ZERO;

  // core conditions
  assign running     = (count_cmd == fcs_pkg::CMD_COUNT);
  assign bidir_mode  = (count_mode >= fcs_pkg::MODE_FIRST_BI) && (count_mode <= fcs_pkg::MODE_LAST);
  assign single_mode = (count_mode < fcs_pkg::MODE_FIRST_BI);
  assign up_evt      = ce & running & counting_enabled_bit & step_up & ~step_down;
  assign down_evt    = ce & running & counting_enabled_bit & step_down & ~step_up & bidir_mode;
  assign acc_inc     = accumulator + 32'sd1;
  assign upper_reach = up_evt & (acc_inc >= last_upper_target);
  assign new_cause   = irq_trigger.over | irq_trigger.under | irq_trigger.upper |
                       (irq_trigger.lower & bidir_mode);

  assign count_value       = accumulator;
  assign upper_pattern_out = last_upper_output_pattern;
  assign lower_pattern_out = last_lower_output_pattern;

  // enable mirrors
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      counting_enabled_bit <= 1'b0;
      up_activity_bit      <= 1'b0;
      down_activity_bit    <= 1'b0;
    end else if (ce && running) begin
      counting_enabled_bit <= count_enable;
      up_activity_bit      <= count_enable;
      down_activity_bit    <= count_enable & bidir_mode;
    end
  end

  // fault flag and code; set beats clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_present_bit <= 1'b0;
      fault_code        <= 16'h0000;
    end else if (ce) begin
      if (fault_valid && fault_code_in != 16'h0000) begin
        fault_present_bit <= 1'b1;
        fault_code        <= fault_code_in;
      end else begin
        if (clr[fcs_pkg::BIT_FAULT])
          fault_present_bit <= 1'b0;
        if (wr_en && hit(paddr, fcs_pkg::OFS_FAULT))
          fault_code <= pwdata[15:0];
      end
    end
  end

  // accumulator
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      accumulator <= 32'sh00000000;
    end else if (wr_en && hit(paddr, fcs_pkg::OFS_ACCUM)) begin
      accumulator <= pwdata;
    end else if (up_evt) begin
      if (single_mode && upper_reach)
        accumulator <= 32'sh00000000;
      else
        accumulator <= acc_inc;
    end else if (down_evt) begin
      accumulator <= accumulator - 32'sd1;
    end
  end

  // direction holds while the count stands
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      direction_bit <= 1'b1;
    else if (up_evt)
      direction_bit <= 1'b1;
    else if (down_evt)
      direction_bit <= 1'b0;
  end

  // single shot, over and under flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      single_shot_done_bit <= 1'b0;
      over_limit_bit       <= 1'b0;
      under_limit_bit      <= 1'b0;
    end else if (ce) begin
      if (upper_reach && single_mode)
        single_shot_done_bit <= 1'b1;
      else if (clr[fcs_pkg::BIT_SHOT_DONE])
        single_shot_done_bit <= 1'b0;
      if (up_evt && accumulator == over_setting)
        over_limit_bit <= 1'b1;
      else if (clr[fcs_pkg::BIT_OVER])
        over_limit_bit <= 1'b0;
      if (down_evt && accumulator == under_setting)
        under_limit_bit <= 1'b1;
      else if (clr[fcs_pkg::BIT_UNDER])
        under_limit_bit <= 1'b0;
    end
  end

  // target comparisons refreshed while running
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      upper_target_hit_bit <= 1'b0;
      lower_target_hit_bit <= 1'b0;
    end else if (ce && running) begin
      upper_target_hit_bit <= (accumulator >= last_upper_target);
      lower_target_hit_bit <= bidir_mode & (accumulator <= last_lower_target);
    end else if (ce) begin
      if (clr[fcs_pkg::BIT_UPPER_HIT])
        upper_target_hit_bit <= 1'b0;
      if (clr[fcs_pkg::BIT_LOWER_HIT])
        lower_target_hit_bit <= 1'b0;
    end
  end

  // interrupt cause flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      over_limit_irq_cause   <= 1'b0;
      under_limit_irq_cause  <= 1'b0;
      upper_target_irq_cause <= 1'b0;
      lower_target_irq_cause <= 1'b0;
    end else if (ce && new_cause) begin
      over_limit_irq_cause   <= irq_trigger.over;
      under_limit_irq_cause  <= irq_trigger.under;
      upper_target_irq_cause <= irq_trigger.upper;
      lower_target_irq_cause <= irq_trigger.lower & bidir_mode;
    end else if (ce) begin
      if (clr[fcs_pkg::BIT_CAUSE_OVER])
        over_limit_irq_cause <= 1'b0;
      if (clr[fcs_pkg::BIT_CAUSE_UNDER])
        under_limit_irq_cause <= 1'b0;
      if (clr[fcs_pkg::BIT_CAUSE_UPPER])
        upper_target_irq_cause <= 1'b0;
      if (clr[fcs_pkg::BIT_CAUSE_LOWER])
        lower_target_irq_cause <= 1'b0;
    end
  end

  // limit switch table position
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      limit_table_position <= fcs_pkg::POSITION_START;
    else if (upper_reach && table_at_end)
      limit_table_position <= fcs_pkg::POSITION_START;
    else if (ce && running && table_step)
      limit_table_position <= limit_table_position + 16'h0001;
  end

  // targets and patterns
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_upper_target         <= 32'sh00000000;
      last_lower_target         <= 32'sh00000000;
      last_upper_output_pattern <= fcs_pkg::WORD_ZERO;
      last_lower_output_pattern <= fcs_pkg::WORD_ZERO;
    end else if (ce && preset_load) begin
      last_upper_target         <= preset_in.upper_target;
      last_lower_target         <= preset_in.lower_target;
      last_upper_output_pattern <= preset_in.upper_pattern;
      last_lower_output_pattern <= preset_in.lower_pattern;
    end else if (wr_en) begin
      if (hit(paddr, fcs_pkg::OFS_UPPER_PAT))
        last_upper_output_pattern <= pwdata;
      if (hit(paddr, fcs_pkg::OFS_LOWER_PAT))
        last_lower_output_pattern <= pwdata;
    end
  end

  // over and under limit settings
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      over_setting  <= fcs_pkg::OVER_LIM_RST;
      under_setting <= fcs_pkg::UNDER_LIM_RST;
    end else if (wr_en) begin
      if (hit(paddr, fcs_pkg::OFS_OVER_LIM))
        over_setting <= pwdata;
      if (hit(paddr, fcs_pkg::OFS_UNDER_LIM))
        under_setting <= pwdata;
    end
  end

  // read mux
  always_comb begin
    flags_word = fcs_pkg::WORD_ZERO;
    flags_word[fcs_pkg::BIT_ENABLED]     = counting_enabled_bit;
    flags_word[fcs_pkg::BIT_FAULT]       = fault_present_bit;
    flags_word[fcs_pkg::BIT_UP_ACT]      = up_activity_bit;
    flags_word[fcs_pkg::BIT_DOWN_ACT]    = down_activity_bit;
    flags_word[fcs_pkg::BIT_SHOT_DONE]   = single_shot_done_bit;
    flags_word[fcs_pkg::BIT_OVER]        = over_limit_bit;
    flags_word[fcs_pkg::BIT_UNDER]       = under_limit_bit;
    flags_word[fcs_pkg::BIT_DIRECTION]   = direction_bit;
    flags_word[fcs_pkg::BIT_UPPER_HIT]   = upper_target_hit_bit;
    flags_word[fcs_pkg::BIT_LOWER_HIT]   = lower_target_hit_bit;
    flags_word[fcs_pkg::BIT_CAUSE_OVER]  = over_limit_irq_cause;
    flags_word[fcs_pkg::BIT_CAUSE_UNDER] = under_limit_irq_cause;
    flags_word[fcs_pkg::BIT_CAUSE_UPPER] = upper_target_irq_cause;
    flags_word[fcs_pkg::BIT_CAUSE_LOWER] = lower_target_irq_cause;
    case (12'(paddr))
      fcs_pkg::OFS_FLAGS:     next_prdata = flags_word;
      fcs_pkg::OFS_POSITION:  next_prdata = {16'h0000, limit_table_position};
      fcs_pkg::OFS_FAULT:     next_prdata = {16'h0000, fault_code};
      fcs_pkg::OFS_ACCUM:     next_prdata = accumulator;
      fcs_pkg::OFS_UPPER_TGT: next_prdata = last_upper_target;
      fcs_pkg::OFS_LOWER_TGT: next_prdata = last_lower_target;
      fcs_pkg::OFS_UPPER_PAT: next_prdata = last_upper_output_pattern;
      fcs_pkg::OFS_LOWER_PAT: next_prdata = last_lower_output_pattern;
      fcs_pkg::OFS_OVER_LIM:  next_prdata = over_setting;
      fcs_pkg::OFS_UNDER_LIM: next_prdata = under_setting;
      default:                next_prdata = fcs_pkg::WORD_ZERO;
    endcase
  end

  // read data captured in the setup phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      prdata <= fcs_pkg::WORD_ZERO;
    else if (setup)
      prdata <= pwrite ? fcs_pkg::WORD_ZERO : next_prdata;
  end

endmodule

`default_nettype wire

// >>> verification/fcs_status_monitor.sv
// Purpose: port-level checks for the counter status block
// Assumes: one clock, async active-low reset
// Notes:   attached by bind
`timescale 1ns/1ns
`default_nettype none
module fcs_status_monitor #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 arst_n,
  input wire logic                 ce,
  // apb
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [ADDR_W-1:0]    paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pslverr,
  input wire logic [31:0]          prdata,
  // core side
  input wire logic [7:0]           count_cmd,
  input wire logic                 count_enable,
  input wire logic [3:0]           count_mode,
  input wire logic                 step_up,
  input wire logic                 step_down,
  input wire logic                 preset_load,
  input wire fcs_pkg::fcs_preset_t preset_in,
  input wire logic [31:0]          count_value,
  input wire logic [31:0]          upper_pattern_out,
  input wire logic [31:0]          lower_pattern_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic run;
  logic bidir;
  logic wr;
  logic rdset;
  logic acc_wr;
  assign run    = ce && count_cmd == fcs_pkg::CMD_COUNT;
  assign bidir  = count_mode >= fcs_pkg::MODE_FIRST_BI && count_mode <= fcs_pkg::MODE_LAST;
  assign wr     = psel && penable && pwrite && ce;
  assign rdset  = psel && !penable && !pwrite && ce;
  assign acc_wr = wr && paddr == ADDR_W'(fcs_pkg::OFS_ACCUM);
  // enabled bit lags the enable input by one cycle
  sequence s_armed;
    run && count_enable;
  endsequence
  sequence s_up;
    run && step_up && !step_down && !acc_wr && bidir;
  endsequence
  sequence s_down;
    run && step_down && !step_up && !acc_wr && bidir;
  endsequence
  AST_STEP_UP: assert property (s_armed ##1 s_up |=> count_value == $past(count_value) + 32'h1)
    else $error("step up did not add one");
  AST_STEP_DOWN: assert property (s_armed ##1 s_down |=> count_value == $past(count_value) - 32'h1)
    else $error("step down did not take one");
  AST_IDLE_HOLD: assert property (!run && !acc_wr |=> $stable(count_value))
    else $error("count moved while not running");
  AST_ACC_WRITE: assert property (acc_wr |=> count_value == $past(pwdata))
    else $error("accumulator write not applied");
  AST_PAT_WRITE: assert property (wr && paddr == ADDR_W'(fcs_pkg::OFS_UPPER_PAT) |=>
    upper_pattern_out == $past(pwdata))
    else $error("upper pattern write not applied");
  AST_PRESET_LOAD: assert property (run && preset_load && !wr |=>
    upper_pattern_out == $past(preset_in.upper_pattern) && lower_pattern_out == $past(preset_in.lower_pattern))
    else $error("preset patterns not copied");
  AST_READ_ACC: assert property (rdset && paddr == ADDR_W'(fcs_pkg::OFS_ACCUM) |=>
    prdata == $past(count_value))
    else $error("accumulator read wrong");
  AST_READ_PAT: assert property (rdset && paddr == ADDR_W'(fcs_pkg::OFS_LOWER_PAT) |=>
    prdata == $past(lower_pattern_out))
    else $error("lower pattern read wrong");
  // every aligned word up to the last limit register is mapped
  AST_UNMAPPED: assert property (psel && penable |->
    pslverr == ((paddr > ADDR_W'(fcs_pkg::OFS_UNDER_LIM)) || (paddr[1:0] != 2'b00)))
    else $error("slave error flag wrong");
endmodule
bind fcs_status_block fcs_status_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .clk(clk), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pslverr(pslverr), .prdata(prdata), .count_cmd(count_cmd), .count_enable(count_enable),
  .count_mode(count_mode), .step_up(step_up), .step_down(step_down), .preset_load(preset_load),
  .preset_in(preset_in), .count_value(count_value), .upper_pattern_out(upper_pattern_out),
  .lower_pattern_out(lower_pattern_out)
);
`default_nettype wire

// >>> verification/tb.sv
// Purpose: self-checking bench for the counter status block
// Assumes: zero-wait apb slave, sticky flags write-one-to-clear (enable, activity and direction bits ignore writes)
// Notes:   presets upper 10, lower 2
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic                 clk;
  logic                 arst_n;
  logic                 ce;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [11:0]          paddr;
  logic [31:0]          pwdata;
  logic                 pready;
  logic                 pslverr;
  logic [31:0]          prdata;
  logic [7:0]           count_cmd;
  logic                 count_enable;
  logic [3:0]           count_mode;
  logic                 step_up;
  logic                 step_down;
  logic                 preset_load;
  fcs_pkg::fcs_preset_t preset_in;
  fcs_pkg::fcs_irq_t    irq_trigger;
  logic                 fault_valid;
  logic [15:0]          fault_code_in;
  logic                 table_step;
  logic                 table_at_end;
  logic [31:0]          count_value;
  logic [31:0]          upper_pattern_out;
  logic [31:0]          lower_pattern_out;
  logic [31:0]          rd;
  logic                 err;
  int                   fails;
  int                   n_compared;

  fcs_status_block uut (
    .clk(clk), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .count_cmd(count_cmd),
    .count_enable(count_enable), .count_mode(count_mode), .step_up(step_up), .step_down(step_down),
    .preset_load(preset_load), .preset_in(preset_in), .irq_trigger(irq_trigger), .fault_valid(fault_valid),
    .fault_code_in(fault_code_in), .table_step(table_step), .table_at_end(table_at_end),
    .count_value(count_value), .upper_pattern_out(upper_pattern_out), .lower_pattern_out(lower_pattern_out)
  );

  always #4 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the watchdog ends a wait for pready
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask);
    apb(1'b0, a, 32'h0);
    chk(rd & mask, exp);
  endtask

  task automatic step(input logic up, input int n);
    repeat (n) begin
      @(posedge clk);
      step_up   <= up;
      step_down <= !up;
      @(posedge clk);
      step_up   <= 1'b0;
      step_down <= 1'b0;
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic pulse(input logic [3:0] v, input logic [15:0] code, input logic tbl);
    @(posedge clk);
    irq_trigger   <= v;
    fault_valid   <= code != 16'h0000;
    fault_code_in <= code;
    table_step    <= tbl;
    @(posedge clk);
    irq_trigger   <= 4'h0;
    fault_valid   <= 1'b0;
    table_step    <= 1'b0;
  endtask

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    summarize();
  end

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    count_cmd = 8'h00;
    count_enable = 1'b0;
    count_mode = 4'h0;
    step_up = 1'b0;
    step_down = 1'b0;
    preset_load = 1'b0;
    preset_in = '0;
    irq_trigger = '0;
    fault_valid = 1'b0;
    fault_code_in = 16'h0000;
    table_step = 1'b0;
    table_at_end = 1'b0;
    fails = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rchk(fcs_pkg::OFS_FLAGS, 32'h00000080, ALL);
    rchk(fcs_pkg::OFS_POSITION, 32'h0, ALL);
    rchk(fcs_pkg::OFS_OVER_LIM, 32'h7FFFFFFF, ALL);
    rchk(fcs_pkg::OFS_UNDER_LIM, 32'h80000000, ALL);
    rchk(12'h028, 32'h0, ALL);
    chk({31'h0, err}, 32'h00000001);
    rchk(12'h002, 32'h0, ALL);
    chk({31'h0, err}, 32'h00000001);
    rchk(fcs_pkg::OFS_FLAGS, 32'h00000080, ALL);
    chk({31'h0, err}, 32'h00000000);
    count_cmd    <= fcs_pkg::CMD_COUNT;
    count_enable <= 1'b1;
    @(posedge clk);
    preset_in   <= {32'h0000000A, 32'h00000002, 32'hA5A50F0F, 32'h5A5AF0F0};
    preset_load <= 1'b1;
    @(posedge clk);
    preset_load <= 1'b0;
    for (int m = 0; m < 10; m++) begin
      count_mode <= 4'(m);
      repeat (2) @(posedge clk);
      rchk(fcs_pkg::OFS_FLAGS, (m >= 2) ? 32'h0000000D : 32'h00000005, 32'h0000000D);
    end
    apb(1'b1, fcs_pkg::OFS_FLAGS, 32'h0000008D);
    rchk(fcs_pkg::OFS_FLAGS, 32'h0000008D, 32'h0000008D);
    count_enable <= 1'b0;
    rchk(fcs_pkg::OFS_FLAGS, 32'h0, 32'h0000000D);
    count_enable <= 1'b1;
    apb(1'b1, fcs_pkg::OFS_UPPER_TGT, 32'h00000055);
    rchk(fcs_pkg::OFS_UPPER_TGT, 32'h0000000A, ALL);
    rchk(fcs_pkg::OFS_LOWER_TGT, 32'h00000002, ALL);
    rchk(fcs_pkg::OFS_UPPER_PAT, 32'hA5A50F0F, ALL);
    apb(1'b1, fcs_pkg::OFS_LOWER_PAT, 32'h12345678);
    rchk(fcs_pkg::OFS_LOWER_PAT, 32'h12345678, ALL);
    chk(lower_pattern_out, 32'h12345678);
    apb(1'b1, fcs_pkg::OFS_ACCUM, 32'h00000008);
    step(1'b1, 2);
    rchk(fcs_pkg::OFS_ACCUM, 32'h0000000A, ALL);
    rchk(fcs_pkg::OFS_FLAGS, 32'h00000180, 32'h00000180);
    step(1'b0, 1);
    rchk(fcs_pkg::OFS_ACCUM, 32'h00000009, ALL);
    rchk(fcs_pkg::OFS_FLAGS, 32'h0, 32'h00000180);
    repeat (3) pulse(4'h0, 16'h0000, 1'b1);
    rchk(fcs_pkg::OFS_POSITION, 32'h00000003, ALL);
    table_at_end <= 1'b1;
    step(1'b1, 1);
    rchk(fcs_pkg::OFS_POSITION, 32'h0, ALL);
    table_at_end <= 1'b0;
    count_mode <= 4'h0;
    apb(1'b1, fcs_pkg::OFS_ACCUM, 32'h00000009);
    step(1'b1, 1);
    rchk(fcs_pkg::OFS_ACCUM, 32'h0, ALL);
    rchk(fcs_pkg::OFS_FLAGS, 32'h00000010, 32'h00000010);
    apb(1'b1, fcs_pkg::OFS_FLAGS, 32'h00000010);
    rchk(fcs_pkg::OFS_FLAGS, 32'h0, 32'h00000010);
    count_mode <= 4'h2;
    apb(1'b1, fcs_pkg::OFS_OVER_LIM, 32'h00000005);
    apb(1'b1, fcs_pkg::OFS_ACCUM, 32'h00000005);
    step(1'b1, 1);
    rchk(fcs_pkg::OFS_FLAGS, 32'h00000020, 32'h00000060);
    apb(1'b1, fcs_pkg::OFS_FLAGS, 32'h00000020);
    rchk(fcs_pkg::OFS_FLAGS, 32'h0, 32'h00000060);
    apb(1'b1, fcs_pkg::OFS_UNDER_LIM, 32'h00000003);
    apb(1'b1, fcs_pkg::OFS_ACCUM, 32'h00000003);
    step(1'b0, 1);
    rchk(fcs_pkg::OFS_FLAGS, 32'h00000040, 32'h00000060);
    for (int i = 0; i < 4; i++) begin
      pulse(4'h8 >> i, 16'h0000, 1'b0);
      rchk(fcs_pkg::OFS_FLAGS, 32'h00000400 << i, 32'h00003C00);
    end
    count_mode <= 4'h0;
    pulse(4'h8, 16'h0000, 1'b0);
    pulse(4'h1, 16'h0000, 1'b0);
    rchk(fcs_pkg::OFS_FLAGS, 32'h00000400, 32'h00003C00);
    apb(1'b1, fcs_pkg::OFS_FLAGS, 32'h00000400);
    rchk(fcs_pkg::OFS_FLAGS, 32'h0, 32'h00003C00);
    pulse(4'h0, 16'h0102, 1'b0);
    rchk(fcs_pkg::OFS_FLAGS, 32'h00000002, 32'h00000002);
    rchk(fcs_pkg::OFS_FAULT, 32'h00000102, ALL);
    apb(1'b1, fcs_pkg::OFS_FLAGS, 32'h00000002);
    rchk(fcs_pkg::OFS_FLAGS, 32'h0, 32'h00000002);
    rchk(fcs_pkg::OFS_FAULT, 32'h00000102, ALL);
    // clock enable low freezes the count
    ce <= 1'b0;
    step(1'b1, 2);
    ce <= 1'b1;
    rchk(fcs_pkg::OFS_ACCUM, 32'h00000002, ALL);
    count_cmd <= 8'h00;
    apb(1'b1, fcs_pkg::OFS_ACCUM, 32'h00000007);
    step(1'b1, 2);
    rchk(fcs_pkg::OFS_ACCUM, 32'h00000007, ALL);
    summarize();
  end
endmodule
`default_nettype wire
